/* File: core/mpm_pin_mux.sv */
// Mode pin capture and pin function multiplexer of the external bus.
// Operation
// - Latch six mode pins on the third clock edge after power-on reset release.
// - Sixth mode pin selects byte ordering.
// - Fourth and fifth pins select area 0 width.
// - Area 2 DRAM reuses endian pin as strobe.
// - Area 6 card reuses fifth pin.
// - Area 5 card reuses fourth pin.
// - Serial enable takes receive data pin three.
// - Serial enable drives transmit on pin two.
// - Serial enable uses pin one as clock.
// - Chip-active low forces hardware standby.
// - Select 6 is select or card enable.
// - Select 5 is select or card enable.
// - Lane 0 strobe qualifies D7-D0.
// - Lane 1 strobe qualifies D15-D8.
// - Lane 2 strobe, also card I/O read.
// - Lane 3 strobe, also card I/O write.
// - Column strobe 3: D31-D24, area 2 D15-D8.
// - Column strobe 2: D23-D16, area 2 D7-D0.
// - Column strobe 0: D7-D0, SDRAM CAS, PSRAM OE.
// - Column strobe 1 selects D15-D8.
// - Row strobe serves DRAM, SDRAM, PSRAM enable.
// - Endian pin is input until area 2 DRAM.
`timescale 1ns/1ps
`default_nettype none
module mpm_pin_mux
    import mpm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Mode pins: input, output, output enable (low drives)
    input wire logic [MODE_PIN_COUNT-1:0] modePinIn,
    output logic [MODE_PIN_COUNT-1:0] modePinOut,
    output logic [MODE_PIN_COUNT-1:0] modePinOeN,
    // Chip active input from the board
    input wire logic chipActiveIn,
    // Function enables from software
    input wire logic area2DramEn,
    input wire logic area5CardEn,
    input wire logic area6CardEn,
    input wire logic serialPortEn,
    input wire logic serialClkOutEn,
    // Serial port side
    input wire logic serialTxd,
    input wire logic serialClkOut,
    output logic serialRxd,
    output logic serialClkIn,
    // Access from the bus controller
    input wire logic accessOn,
    input wire logic isWrite,
    input wire logic cardIoAccess,
    input wire logic area2Access,
    input wire logic area5Access,
    input wire logic area6Access,
    input wire logic rowStrobeReq,
    input wire logic colStrobeReq,
    input wire mpm_mem_t memType,
    input wire logic [LANE_COUNT-1:0] laneSel,
    // Configuration out
    output logic bigEndian,
    output mpm_width_t area0Width,
    output logic hwStandby,
    // Bus strobes, active low
    output logic areaFiveSelectN,
    output logic areaSixSelectN,
    output logic sharedRowStrobeN,
    output logic [LANE_COUNT-1:0] laneStrobeN,
    output logic [LANE_COUNT-1:0] colStrobeN
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [MODE_PIN_COUNT-1:0] pinSync;
    logic chipActiveSync;

    for (genvar i = 0; i < MODE_PIN_COUNT; i++) begin : g_sync
        mpm_sync2 #(.RESET_VAL(1'b0)) u_sync (
            .clock(clock),
            .sys_rst(sys_rst),
            .din(modePinIn[i]),
            .dout(pinSync[i])
        );
    end

    // Reset value high so standby is not entered during reset itself.
    mpm_sync2 #(.RESET_VAL(1'b1)) u_ca_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(chipActiveIn),
        .dout(chipActiveSync)
    );

    // ****************************************
    // Mode capture
    // ****************************************
    // The capture is made on the third edge after reset release, once the
    // synchronisers carry the pins; the asynchronous reset only clears it.
    logic captured_q;
    logic captured_d;
    logic [MODE_PIN_COUNT-1:0] mode_q;
    logic [MODE_PIN_COUNT-1:0] mode_d;
    logic [1:0] settle_q;
    logic [1:0] settle_d;

    always_comb begin
        captured_d = captured_q;
        mode_d = mode_q;
        settle_d = settle_q;
        if (!captured_q) begin
            if (settle_q == SETTLE_LAST) begin
                mode_d = pinSync;
                captured_d = 1'b1;
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            captured_q <= 1'b0;
            mode_q <= MODE_RESET;
            settle_q <= 2'h0;
        end else begin
            captured_q <= captured_d;
            mode_q <= mode_d;
            settle_q <= settle_d;
        end
    end

    assign bigEndian = mode_q[MP_ENDIAN];
    assign area0Width = mpm_width_t'({mode_q[MP_W_HI], mode_q[MP_W_LO]});

    // ****************************************
    // Standby and strobe generation
    // ****************************************
    logic liveAccess;
    logic area2Dram;
    logic [LANE_COUNT-1:0] colHit;
    logic [LANE_COUNT-1:0] laneBase;

    assign hwStandby = ~chipActiveSync;
    assign liveAccess = accessOn & ~hwStandby & captured_q;
    assign area2Dram = area2DramEn & area2Access & (memType == MPM_MEM_DRAM);

    always_comb begin
        // Area 2 DRAM is 16 bits wide on the two upper column strobes.
        colHit = laneSel & {LANE_COUNT{colStrobeReq}};
        if (area2Dram) begin
            colHit = {laneSel[1:0], 2'h0} & {LANE_COUNT{colStrobeReq}};
        end
        laneBase = laneSel;
    end

    for (genvar l = 0; l < LANE_COUNT; l++) begin : g_lane
        logic lsN;
        logic csN;
        mpm_strobe_lane u_lane (
            .laneHit(laneBase[l]),
            .colHit(colHit[l]),
            .isWrite(isWrite),
            .accessOn(liveAccess & ~cardIoAccess & ~area2Dram),
            .memType(memType),
            .strobeN(lsN),
            .colStrobeN(csN)
        );
        if (l >= 2) begin : g_io
            // Upper lanes double as card I/O read (2) and write (3).
            logic ioHit;
            assign ioHit = liveAccess & cardIoAccess & ((l == 3) ? isWrite : ~isWrite);
            assign laneStrobeN[l] = lsN & ~ioHit;
        end else begin : g_plain
            assign laneStrobeN[l] = lsN;
        end
        if (l == 0) begin : g_cas0
            // Lane 0 column strobe is also SDRAM CAS and pseudo-SRAM output enable.
            logic memSel;
            assign memSel = liveAccess & colStrobeReq & ~area2Dram &
                ((memType == MPM_MEM_SDRAM) | ((memType == MPM_MEM_PSRAM) & ~isWrite));
            assign colStrobeN[l] = csN & ~memSel;
        end else begin : g_casx
            logic a2Hit;
            assign a2Hit = liveAccess & area2Dram & colHit[l];
            assign colStrobeN[l] = csN & ~a2Hit;
        end
    end

    always_comb begin
        sharedRowStrobeN = ~(liveAccess & rowStrobeReq & ~area2Dram &
            (memType != MPM_MEM_NORMAL));
        // One select line per area; card mode makes it the first card enable.
        areaFiveSelectN = ~(liveAccess & area5Access &
            (area5CardEn ? laneSel[0] : 1'b1));
        areaSixSelectN = ~(liveAccess & area6Access &
            (area6CardEn ? laneSel[0] : 1'b1));
    end

    // ****************************************
    // Mode pin reuse
    // ****************************************
    logic a5Second;
    logic a6Second;
    logic a2Row;

    // Second card enable covers the odd byte of a 16-bit card access.
    assign a5Second = liveAccess & area5Access & laneSel[1];
    assign a6Second = liveAccess & area6Access & laneSel[1];
    assign a2Row = liveAccess & area2Dram & rowStrobeReq;

    always_comb begin
        // Undriven pins default to input with output at idle high; the clock pin, serial port on, keeps serialClkOut.
        modePinOut = {MODE_PIN_COUNT{STROBE_IDLE}};
        modePinOeN = {MODE_PIN_COUNT{1'b1}};
        if (captured_q && area2DramEn) begin
            modePinOeN[MP_ENDIAN] = 1'b0;
            modePinOut[MP_ENDIAN] = ~a2Row;
        end
        if (captured_q && area6CardEn) begin
            modePinOeN[MP_W_HI] = 1'b0;
            modePinOut[MP_W_HI] = ~a6Second;
        end
        if (captured_q && area5CardEn) begin
            modePinOeN[MP_W_LO] = 1'b0;
            modePinOut[MP_W_LO] = ~a5Second;
        end
        if (captured_q && serialPortEn) begin
            modePinOeN[MP_TXD] = 1'b0;
            modePinOut[MP_TXD] = serialTxd;
            modePinOeN[MP_SCK] = ~serialClkOutEn;
            modePinOut[MP_SCK] = serialClkOut;
        end
    end

    always_comb begin
        serialRxd = STROBE_IDLE;
        serialClkIn = 1'b0;
        if (captured_q && serialPortEn) begin
            serialRxd = pinSync[MP_RXD];
            serialClkIn = pinSync[MP_SCK];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_captured;
        captured_q;
    endsequence

    a_mode_frozen: assert property (@(posedge clock) disable iff (sys_rst)
        s_captured |=> $stable(mode_q))
        else $error("mode changed after capture");
    a_capture_time: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(captured_q) |-> $past(settle_q) == SETTLE_LAST)
        else $error("capture at wrong time");
    a_endian_map: assert property (@(posedge clock) disable iff (sys_rst)
        bigEndian == mode_q[MP_ENDIAN])
        else $error("endian mismatch");
    a_width_map: assert property (@(posedge clock) disable iff (sys_rst)
        area0Width[1] == mode_q[MP_W_HI] && area0Width[0] == mode_q[MP_W_LO])
        else $error("width mismatch");
    a_endian_input: assert property (@(posedge clock) disable iff (sys_rst)
        !area2DramEn |-> modePinOeN[MP_ENDIAN])
        else $error("endian pin driven while DRAM off");
    a_row_pin: assert property (@(posedge clock) disable iff (sys_rst)
        a2Row |-> !modePinOeN[MP_ENDIAN] && !modePinOut[MP_ENDIAN])
        else $error("row strobe not on pin");
    a_card_six: assert property (@(posedge clock) disable iff (sys_rst)
        captured_q && area6CardEn |-> !modePinOeN[MP_W_HI])
        else $error("area 6 second enable not driven");
    a_card_five: assert property (@(posedge clock) disable iff (sys_rst)
        captured_q && area5CardEn |-> !modePinOeN[MP_W_LO])
        else $error("area 5 second enable not driven");
    a_txd_path: assert property (@(posedge clock) disable iff (sys_rst)
        captured_q && serialPortEn |-> modePinOut[MP_TXD] == serialTxd)
        else $error("transmit data not on pin");
    a_rxd_path: assert property (@(posedge clock) disable iff (sys_rst)
        captured_q && serialPortEn |-> serialRxd == pinSync[MP_RXD])
        else $error("receive data not from pin");
    a_standby_in: assert property (@(posedge clock) disable iff (sys_rst)
        hwStandby |-> sharedRowStrobeN && (&laneStrobeN) && (&colStrobeN))
        else $error("strobe active in standby");
    a_mux_release: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(serialPortEn) |-> modePinOeN[MP_TXD])
        else $error("pin not returned to input");
endmodule // mpm_pin_mux
`default_nettype wire

/* File: core/mpm_pkg.sv */
// Package with the constants shared by the mode pin function multiplexer.
package mpm_pkg;
    // ****************************************
    // Mode pin positions
    // ****************************************
    localparam int MODE_PIN_COUNT = 6;
    localparam int MP_SCK = 0;
    localparam int MP_TXD = 1;
    localparam int MP_RXD = 2;
    localparam int MP_W_LO = 3;
    localparam int MP_W_HI = 4;
    localparam int MP_ENDIAN = 5;
    // Strobes are active low; the idle level is high.
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [5:0] MODE_RESET = 6'h00;
    // Settle count value at which the synchronised mode pins are captured.
    localparam logic [1:0] SETTLE_LAST = 2'h2;
    localparam int LANE_COUNT = 4;
    // Area 0 data bus width codes as seen on the two width pins.
    typedef enum logic [1:0] {
        MPM_W_RSVD = 2'h0,
        MPM_W_8 = 2'h1,
        MPM_W_16 = 2'h2,
        MPM_W_32 = 2'h3
    } mpm_width_t;
    // Memory type of the area being accessed.
    typedef enum logic [1:0] {
        MPM_MEM_NORMAL = 2'h0,
        MPM_MEM_PSRAM = 2'h1,
        MPM_MEM_SDRAM = 2'h2,
        MPM_MEM_DRAM = 2'h3
    } mpm_mem_t;
endpackage

/* File: core/mpm_sync2.sv */
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/1ps
`default_nettype none
module mpm_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Data
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule // mpm_sync2
`default_nettype wire

/* File: core/mpm_strobe_lane.sv */
// One byte lane: picks the active-low strobe and column strobe for its lane.
`timescale 1ns/1ps
`default_nettype none
module mpm_strobe_lane
    import mpm_pkg::*;
(
    // Access qualifiers
    input wire logic laneHit,
    input wire logic colHit,
    input wire logic isWrite,
    input wire logic accessOn,
    input wire mpm_mem_t memType,
    // Lane strobes, active low
    output logic strobeN,
    output logic colStrobeN
);
    always_comb begin
        strobeN = STROBE_IDLE;
        colStrobeN = STROBE_IDLE;
        if (accessOn) begin
            unique case (memType)
                // Write enable only on writes to the lane.
                MPM_MEM_NORMAL, MPM_MEM_PSRAM: begin
                    strobeN = ~(laneHit & isWrite);
                end
                // Data mask: low keeps the lane, high masks it.
                MPM_MEM_SDRAM: begin
                    strobeN = ~laneHit;
                end
                MPM_MEM_DRAM: begin
                    colStrobeN = ~colHit;
                end
            endcase
        end
    end
endmodule // mpm_strobe_lane
`default_nettype wire

/* File: tb/mpm_board_model.sv */
// Board side model: mode straps, serial receive source and reset logic.
`timescale 1ns/1ps
`default_nettype none
module mpm_board_model (
    // Reset and standby request
    input wire logic sys_rst,
    input wire logic standbyReq,
    // Board drive
    input wire logic [5:0] strapVal,
    input wire logic rxdDrive,
    input wire logic rxdBit,
    // Device pin drive
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOeN,
    output logic [5:0] pinLevel,
    output logic chipActiveIn
);
    logic [5:0] board;

    // Straps are resistors, so a pin the device does not drive shows its strap level, except pin 2, which shows rxdBit while rxdDrive is set.
    always_comb begin
        board = strapVal;
        if (rxdDrive) begin
            board[2] = rxdBit;
        end
        for (int i = 0; i < 6; i++) begin
            pinLevel[i] = pinOeN[i] ? board[i] : pinOut[i];
        end
    end

    assign chipActiveIn = sys_rst | ~standbyReq;
endmodule // mpm_board_model
`default_nettype wire

/* File: tb/mode_pin_function_mux_tb.sv */
// Self-checking bench of the mode pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
module mode_pin_function_mux_tb import mpm_pkg::*; ();
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic standbyReq = 1'b0;
    logic rxdDrive = 1'b0;
    logic rxdBit = 1'b0;
    logic [5:0] strapVal = 6'h00;
    logic [5:0] cap, pinLevel, pinOut, pinOeN;
    logic chipActiveIn, a2En, a5En, a6En, serEn, sckEn, txd, sckOut, rxdOut, sckIn;
    logic accessOn, isWrite, cardIo, a2Acc, a5Acc, a6Acc, rowReq, colReq;
    logic bigEndian, hwStandby, sel5N, sel6N, rowN;
    logic [3:0] laneSel, laneN, colN;
    mpm_mem_t memType;
    mpm_width_t area0Width;
    int errTotal = 0;
    int checked = 0;

    always #50 clock = ~clock;

    mpm_board_model board (.sys_rst(sys_rst), .standbyReq(standbyReq), .strapVal(strapVal),
        .rxdDrive(rxdDrive), .rxdBit(rxdBit), .pinOut(pinOut), .pinOeN(pinOeN),
        .pinLevel(pinLevel), .chipActiveIn(chipActiveIn));

    mpm_pin_mux dut (.clock(clock), .sys_rst(sys_rst), .modePinIn(pinLevel),
        .modePinOut(pinOut), .modePinOeN(pinOeN), .chipActiveIn(chipActiveIn),
        .area2DramEn(a2En), .area5CardEn(a5En), .area6CardEn(a6En), .serialPortEn(serEn),
        .serialClkOutEn(sckEn), .serialTxd(txd), .serialClkOut(sckOut), .serialRxd(rxdOut),
        .serialClkIn(sckIn), .accessOn(accessOn), .isWrite(isWrite), .cardIoAccess(cardIo),
        .area2Access(a2Acc), .area5Access(a5Acc), .area6Access(a6Acc), .rowStrobeReq(rowReq),
        .colStrobeReq(colReq), .memType(memType), .laneSel(laneSel), .bigEndian(bigEndian),
        .area0Width(area0Width), .hwStandby(hwStandby), .areaFiveSelectN(sel5N),
        .areaSixSelectN(sel6N), .sharedRowStrobeN(rowN), .laneStrobeN(laneN),
        .colStrobeN(colN));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic idle;
        {accessOn, isWrite, cardIo, a2Acc, a5Acc, a6Acc, rowReq, colReq} = 8'h00;
        memType = MPM_MEM_NORMAL;
        laneSel = 4'h0;
    endtask

    // Write enables follow the lanes; a data mask follows them on reads as well.
    function automatic logic [3:0] expLane(mpm_mem_t m, logic w, logic [3:0] l);
        if (m == MPM_MEM_SDRAM || w) begin
            return ~l;
        end
        return 4'hf;
    endfunction

    function automatic logic [3:0] expCol(logic a2, logic [3:0] l);
        return a2 ? {~l[1:0], 2'h3} : ~l;
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #(100 * 1000);
        errTotal++;
        summarize();
    end

    initial begin
        idle();
        {a2En, a5En, a6En, serEn, sckEn, txd, sckOut} = 7'h00;
        void'($urandom(32'h317a));
        strapVal = 6'($urandom);
        cap = strapVal;
        step(8);
        sys_rst = 1'b0;
        step(5);
        check(bigEndian, cap[MP_ENDIAN]);
        check(area0Width, cap[MP_W_HI:MP_W_LO]);
        check(pinOeN, 6'h3f);
        strapVal = ~cap;
        step(4);
        check({bigEndian, area0Width}, {cap[5], cap[4:3]});
        $display("capture test done");
        for (int i = 0; i < 40; i++) begin
            memType = mpm_mem_t'($urandom_range(2));
            isWrite = 1'($urandom);
            laneSel = (i == 0) ? 4'hf : 4'($urandom);
            rowReq = 1'($urandom);
            colReq = 1'($urandom);
            accessOn = 1'b1;
            step(1);
            check(laneN, expLane(memType, isWrite, laneSel));
            if (memType != MPM_MEM_NORMAL) begin
                check({rowN, colN[0]}, {~rowReq, ~(colReq & (memType == MPM_MEM_SDRAM || !isWrite))});
            end
        end
        for (int i = 0; i < 24; i++) begin
            memType = MPM_MEM_DRAM;
            laneSel = 4'($urandom);
            {a2Acc, rowReq} = 2'($urandom);
            a2En = a2Acc;
            colReq = 1'b1;
            step(1);
            check(colN, expCol(a2Acc, laneSel));
            check(pinOeN[5], {~a2En});
            if (a2Acc) begin
                check(pinOut[5], {~rowReq});
            end
        end
        idle();
        a2En = 1'b0;
        $display("strobe test done");
        {a5En, a6En, accessOn, laneSel} = {3'h7, 4'h3};
        for (int k = 0; k < 2; k++) begin
            {a6Acc, a5Acc} = k ? 2'h2 : 2'h1;
            step(1);
            check({sel6N, sel5N}, k ? 2'h1 : 2'h2);
            check({pinOeN[4:3], pinOut[4:3]}, k ? 4'h1 : 4'h2);
        end
        {cardIo, laneSel} = {1'b1, 4'h0};
        for (int w = 0; w < 2; w++) begin
            isWrite = w[0];
            step(1);
            check(laneN[3:2], w ? 2'h1 : 2'h2);
        end
        {a5En, a6En, cardIo} = 3'h0;
        step(1);
        check({sel6N, sel5N, pinOeN[4:3]}, 4'h7);
        idle();
        $display("card test done");
        {serEn, sckEn, rxdDrive} = 3'h7;
        repeat (4) begin
            {txd, sckOut, rxdBit} = 3'($urandom);
            step(3);
            check({rxdOut, pinOut[1:0]}, {rxdBit, txd, sckOut});
            check(pinOeN, 6'h3c);
            check(sckIn, sckOut);
        end
        sckEn = 1'b0;
        step(3);
        check({pinOeN[0], sckIn}, {1'b1, strapVal[0]});
        {serEn, sckEn} = 2'h0;
        step(3);
        check({rxdOut, pinOeN}, 7'h7f);
        $display("serial test done");
        {accessOn, laneSel, standbyReq} = {1'b1, 4'hf, 1'b1};
        memType = MPM_MEM_SDRAM;
        step(3);
        check({hwStandby, laneN}, 5'h1f);
        standbyReq = 1'b0;
        step(3);
        check({hwStandby, laneN}, 5'h00);
        $display("standby test done");
        summarize();
    end
endmodule // mode_pin_function_mux_tb
`default_nettype wire
